// >>> hw/cfg_loader_pkg.sv
package cfg_loader_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int          CFG_BITS   = 11;
  localparam int          NUM_OUT    = 10;
  localparam int          SEL_BIT    = 10;
  localparam int          CNT_W      = 4;

  // ****************************************
  // counts and reset values
  // ****************************************
  localparam logic [3:0]  FILL_COUNT = 4'hB;
  localparam logic [3:0]  CNT_RST    = 4'h0;
  localparam logic [10:0] SHIFT_RST  = 11'h000;
  localparam logic [10:0] CTRL_RST   = 11'h000;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_FILL,
    ST_ARMED,
    ST_LOCKED
  } seq_state_t;

  // shift stage k holds bit 10-k once full: turn stage order into bit order
  function automatic logic [10:0] stage_to_bits_fn(input logic [10:0] stages);
    logic [10:0] r;
    r = 11'h000;
    for (int i = 0; i < CFG_BITS; i++) begin
      r[i] = stages[CFG_BITS-1-i];
    end
    return r;
  endfunction : stage_to_bits_fn

  // bit n governs output 9-n
  function automatic logic [9:0] bits_to_enables_fn(input logic [10:0] bits);
    logic [9:0] r;
    r = 10'h000;
    for (int k = 0; k < NUM_OUT; k++) begin
      r[k] = bits[NUM_OUT-1-k];
    end
    return r;
  endfunction : bits_to_enables_fn

endpackage : cfg_loader_pkg

// >>> hw/cfg_shift_reg.sv
`timescale 1ns/1ps
module cfg_shift_reg
  import cfg_loader_pkg::*;
#(
  parameter int WIDTH = CFG_BITS
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  // control
  input  wire logic             clr_i,
  input  wire logic             shift_i,
  input  wire logic             din_i,
  // contents
  output logic      [WIDTH-1:0] q_o
);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= '0;
    end else if (ce_i) begin
      if (clr_i) begin
        q_o <= '0;
      end else if (shift_i) begin
        q_o <= {q_o[WIDTH-2:0], din_i};
      end
    end
  end

  property p_clear_wins;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ce_i && clr_i) |=> (q_o == '0);
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("shift clear lost");

endmodule : cfg_shift_reg

// >>> hw/fanout_select.sv
`timescale 1ns/1ps
module fanout_select
  import cfg_loader_pkg::*;
#(
  parameter int N = NUM_OUT
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  // effective configuration
  input  wire logic [N-1:0] enables_i,
  input  wire logic         select_i,
  // reference inputs
  input  wire logic         ref_input_a_i,
  input  wire logic         ref_input_b_i,
  // outputs
  output logic      [N-1:0] fanout_output_o,
  output logic      [N-1:0] output_enable_o,
  output logic              chosen_input_o
);

  logic chosen_input;

  assign chosen_input = select_i ? ref_input_b_i : ref_input_a_i;

  // disabled channels are held low, standing in for powered-off drivers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fanout_output_o <= '0;
      output_enable_o <= '0;
      chosen_input_o  <= 1'b0;
    end else if (ce_i) begin
      fanout_output_o <= enables_i & {N{chosen_input}};
      output_enable_o <= enables_i;
      chosen_input_o  <= select_i;
    end
  end

  property p_gate;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      ce_i |=> fanout_output_o == ($past(enables_i) &
        {N{$past(select_i) ? $past(ref_input_b_i) : $past(ref_input_a_i)}});
  endproperty
  a_gate: assert property (p_gate) else $error("output gating wrong");

endmodule : fanout_select

// >>> hw/serial_output_config_loader.sv
`timescale 1ns/1ps
// Function
// - An 11-bit serial shift register feeds a separate 11-bit control register.
// - The control register enables each of ten outputs and picks one of two inputs.
// - Program enable high means programmed mode, low means standard mode.
// - In programmed mode each config clock pulse shifts the serial bit into stage 0.
// - After eleven pulses, one more programmed pulse commits to the control register.
// - Only one commit is accepted per reset; later pulses leave it unchanged.
// - A config clock pulse with enable low resets sequencer, shift and control register.
// - Bit n governs output 9-n and bit 10 is the input select.
// - A low output bit disables its output; a high one passes the selected input.
// - In standard mode all outputs are enabled and the control register is ignored.
// - In standard mode the serial pin selects the input directly.
module serial_output_config_loader
  import cfg_loader_pkg::*;
(
  // clock, reset, enable
  input  wire logic               sys_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               ce_i,
  // configuration pins
  input  wire logic               config_shift_clock_i,
  input  wire logic               serial_in_i,
  input  wire logic               program_enable_i,
  // reference inputs
  input  wire logic               ref_input_a_i,
  input  wire logic               ref_input_b_i,
  // fan-out outputs and status
  output logic      [NUM_OUT-1:0] fanout_output_o,
  output logic      [NUM_OUT-1:0] output_enable_o,
  output logic                    chosen_input_o,
  output logic                    programmed_mode_o,
  output logic                    config_locked_o
);

  // ****************************************
  // config clock edge detection
  // ****************************************
  logic                  ck_prev_r;
  logic                  ck_rise;
  logic                  prog_pulse;
  logic                  reset_pulse;

  // pins are synchronous to sys_clk; one sampled rise is one pulse
  assign ck_rise     = ce_i && config_shift_clock_i && !ck_prev_r;
  assign prog_pulse  = ck_rise && program_enable_i;
  assign reset_pulse = ck_rise && !program_enable_i;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ck_prev_r <= 1'b0;
    end else if (ce_i) begin
      ck_prev_r <= config_shift_clock_i;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  seq_state_t            state_r;
  seq_state_t            state_nxt;
  logic [CNT_W-1:0]      bit_cnt_r;
  logic [CNT_W-1:0]      bit_cnt_nxt;
  logic                  commit;

  assign commit = prog_pulse && (state_r == ST_ARMED);

  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    if (reset_pulse) begin
      state_nxt   = ST_FILL;
      bit_cnt_nxt = CNT_RST;
    end else if (prog_pulse) begin
      unique case (state_r)
        ST_FILL: begin
          bit_cnt_nxt = bit_cnt_r + 4'h1;
          if (bit_cnt_nxt == FILL_COUNT) begin
            state_nxt = ST_ARMED;
          end
        end
        ST_ARMED: begin
          state_nxt = ST_LOCKED;
        end
        ST_LOCKED: begin
          state_nxt = ST_LOCKED;
        end
        default: begin
          state_nxt   = ST_FILL;
          bit_cnt_nxt = CNT_RST;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r   <= ST_FILL;
      bit_cnt_r <= CNT_RST;
    end else if (ce_i) begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // ****************************************
  // shift register
  // ****************************************
  logic [CFG_BITS-1:0]   shift_q;

  // the commit pulse shifts too; the commit takes contents from before that edge
  cfg_shift_reg #(
    .WIDTH (CFG_BITS)
  ) u_shift (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .clr_i     (reset_pulse),
    .shift_i   (prog_pulse),
    .din_i     (serial_in_i),
    .q_o       (shift_q)
  );

  // ****************************************
  // control register
  // ****************************************
  logic [CFG_BITS-1:0]   ctrl_r;

  // stored in bit order: ctrl_r[n] is configuration bit n
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (ce_i) begin
      if (reset_pulse) begin
        ctrl_r <= CTRL_RST;
      end else if (commit) begin
        ctrl_r <= stage_to_bits_fn(shift_q);
      end
    end
  end

  // ****************************************
  // effective configuration
  // ****************************************
  logic [NUM_OUT-1:0]    eff_enables;
  logic                  eff_select;

  // standard mode bypasses the control register entirely
  assign eff_enables = program_enable_i ? bits_to_enables_fn(ctrl_r) : '1;
  assign eff_select  = program_enable_i ? ctrl_r[SEL_BIT] : serial_in_i;

  fanout_select #(
    .N (NUM_OUT)
  ) u_fanout (
    .sys_clk_i       (sys_clk_i),
    .nrst_i          (nrst_i),
    .ce_i            (ce_i),
    .enables_i       (eff_enables),
    .select_i        (eff_select),
    .ref_input_a_i   (ref_input_a_i),
    .ref_input_b_i   (ref_input_b_i),
    .fanout_output_o (fanout_output_o),
    .output_enable_o (output_enable_o),
    .chosen_input_o  (chosen_input_o)
  );

  // ****************************************
  // status
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      programmed_mode_o <= 1'b0;
      config_locked_o   <= 1'b0;
    end else if (ce_i) begin
      programmed_mode_o <= program_enable_i;
      config_locked_o   <= (state_nxt == ST_LOCKED);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_shift_first;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      prog_pulse |=> (shift_q[0] == $past(serial_in_i));
  endproperty
  a_shift_first: assert property (p_shift_first) else $error("stage 0 missed bit");

  property p_shift_move;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      prog_pulse |=> (shift_q[CFG_BITS-1:1] == $past(shift_q[CFG_BITS-2:0]));
  endproperty
  a_shift_move: assert property (p_shift_move) else $error("stages did not move");

  property p_commit;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (prog_pulse && state_r == ST_ARMED)
        |=> (ctrl_r == stage_to_bits_fn($past(shift_q))) && (state_r == ST_LOCKED);
  endproperty
  a_commit: assert property (p_commit) else $error("commit not taken");

  property p_armed_count;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_r == ST_ARMED) |-> (bit_cnt_r == FILL_COUNT);
  endproperty
  a_armed_count: assert property (p_armed_count) else $error("armed before eleven bits");

  property p_locked;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_r == ST_LOCKED && !reset_pulse) |=> $stable(ctrl_r) && (state_r == ST_LOCKED);
  endproperty
  a_locked: assert property (p_locked) else $error("second commit taken");

  property p_reset_pulse;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      reset_pulse |=> (shift_q == SHIFT_RST) && (ctrl_r == CTRL_RST)
        && (state_r == ST_FILL) && (bit_cnt_r == CNT_RST);
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse ignored");

  property p_precommit;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_r != ST_LOCKED) |-> (ctrl_r == CTRL_RST);
  endproperty
  a_precommit: assert property (p_precommit) else $error("control changed early");

  property p_mode;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      ce_i |=> (programmed_mode_o == $past(program_enable_i));
  endproperty
  a_mode: assert property (p_mode) else $error("mode flag wrong");

  property p_std_all_on;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ce_i && !program_enable_i) |=> (output_enable_o == '1);
  endproperty
  a_std_all_on: assert property (p_std_all_on) else $error("standard mode output off");

  property p_std_select;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ce_i && !program_enable_i) |=> (chosen_input_o == $past(serial_in_i));
  endproperty
  a_std_select: assert property (p_std_select) else $error("serial pin not selecting");

  property p_prog_map;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ce_i && program_enable_i) |=> (output_enable_o == bits_to_enables_fn($past(ctrl_r)))
        && (chosen_input_o == $past(ctrl_r[SEL_BIT]));
  endproperty
  a_prog_map: assert property (p_prog_map) else $error("bit to output map wrong");

  property p_locked_flag;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      config_locked_o == (state_r == ST_LOCKED);
  endproperty
  a_locked_flag: assert property (p_locked_flag) else $error("lock flag off state");

  property p_idle_shift;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (!prog_pulse && !reset_pulse) |=> $stable(shift_q);
  endproperty
  a_idle_shift: assert property (p_idle_shift) else $error("shift without rise");

  property p_fill_count;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (prog_pulse && state_r == ST_FILL) |=> (bit_cnt_r == $past(bit_cnt_r) + 4'h1);
  endproperty
  a_fill_count: assert property (p_fill_count) else $error("bit count skipped");

  property p_cnt_bound;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (bit_cnt_r <= FILL_COUNT);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("bit count overran");

  property p_early_commit;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (prog_pulse && state_r == ST_FILL) |=> (ctrl_r == CTRL_RST) && !config_locked_o;
  endproperty
  a_early_commit: assert property (p_early_commit) else $error("early commit");

  property p_armed_wait;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (state_r == ST_ARMED && !prog_pulse && !reset_pulse) |=> (state_r == ST_ARMED);
  endproperty
  a_armed_wait: assert property (p_armed_wait) else $error("armed state lost");

  property p_commit_once;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (prog_pulse && state_r == ST_LOCKED) |=> (state_r == ST_LOCKED) && config_locked_o;
  endproperty
  a_commit_once: assert property (p_commit_once) else $error("lock reopened");

  // standard mode: whole bank follows the pin-selected input
  property p_std_fanout;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ce_i && !program_enable_i) |=> fanout_output_o ==
        {NUM_OUT{$past(serial_in_i) ? $past(ref_input_b_i) : $past(ref_input_a_i)}};
  endproperty
  a_std_fanout: assert property (p_std_fanout) else $error("standard fanout wrong");

  property p_prog_fanout;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (ce_i && program_enable_i) |=> fanout_output_o == (bits_to_enables_fn($past(ctrl_r))
        & {NUM_OUT{$past(ctrl_r[SEL_BIT]) ? $past(ref_input_b_i) : $past(ref_input_a_i)}});
  endproperty
  a_prog_fanout: assert property (p_prog_fanout) else $error("programmed fanout wrong");

  // a frozen block must not see a pin rise, or a bit would be lost
  property p_freeze;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      !ce_i |=> $stable(ctrl_r) && $stable(shift_q) && $stable(state_r)
        && $stable(bit_cnt_r) && $stable(fanout_output_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule : serial_output_config_loader

// >>> verif/cfg_controller_model.sv
`timescale 1ns/1ps
module cfg_controller_model (
  // clock
  input  wire logic sys_clk_i,
  // configuration pins
  output logic      config_shift_clock_o,
  output logic      serial_in_o,
  output logic      program_enable_o
);
  initial begin
    config_shift_clock_o = 1'b0;
    serial_in_o          = 1'b0;
    program_enable_o     = 1'b0;
  end

  // one rise, then the line idles low
  task automatic pulse(input logic b, input int gap);
    @(negedge sys_clk_i);
    serial_in_o          = b;
    config_shift_clock_o = 1'b1;
    @(negedge sys_clk_i);
    config_shift_clock_o = 1'b0;
    // hold time over: stale level not kept
    serial_in_o          = ~b;
    repeat (gap) @(negedge sys_clk_i);
  endtask : pulse

  task automatic pin_reset();
    @(negedge sys_clk_i);
    program_enable_o = 1'b0;
    pulse(1'($urandom), 0);
  endtask : pin_reset

  task automatic std(input logic sel);
    @(negedge sys_clk_i);
    program_enable_o = 1'b0;
    serial_in_o      = sel;
  endtask : std

  task automatic load(input logic [10:0] w, input int n, input int gap);
    @(negedge sys_clk_i);
    program_enable_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      pulse(w[i], gap);
    end
  endtask : load

  task automatic commit(input int gap);
    pulse(1'($urandom), gap);
  endtask : commit
endmodule : cfg_controller_model

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  import cfg_loader_pkg::*;
  logic               sys_clk_i;
  logic               nrst_i;
  logic               ce_i;
  logic               ref_a;
  logic               ref_b;
  logic               ck;
  logic               si;
  logic               en;
  logic [NUM_OUT-1:0] fan;
  logic [NUM_OUT-1:0] oen;
  logic               chosen;
  logic               pmode;
  logic               locked;
  int                 fails;
  int                 check_count;
  logic [10:0]        w;
  logic [10:0]        corner [4] = '{11'h7FF, 11'h001, 11'h400, 11'h2AA};

  serial_output_config_loader dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .config_shift_clock_i(ck), .serial_in_i(si), .program_enable_i(en),
    .ref_input_a_i(ref_a), .ref_input_b_i(ref_b),
    .fanout_output_o(fan), .output_enable_o(oen), .chosen_input_o(chosen),
    .programmed_mode_o(pmode), .config_locked_o(locked)
  );

  cfg_controller_model ctl (
    .sys_clk_i(sys_clk_i), .config_shift_clock_o(ck), .serial_in_o(si),
    .program_enable_o(en)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // bit n of the word governs output 9-n
  function automatic logic [9:0] exp_en(input logic [10:0] bits);
    logic [9:0] r;
    for (int k = 0; k < NUM_OUT; k++) begin
      r[k] = bits[9-k];
    end
    return r;
  endfunction : exp_en

  task automatic check_outs(input logic [9:0] e, input logic s);
    logic [9:0] f;
    @(negedge sys_clk_i);
    ref_a = 1'($urandom);
    ref_b = 1'($urandom);
    repeat (2) @(negedge sys_clk_i);
    f = s ? {10{ref_b}} : {10{ref_a}};
    chk("enables", {1'b0, e}, {1'b0, oen});
    chk("select", {10'h000, s}, {10'h000, chosen});
    chk("fanout", {1'b0, e & f}, {1'b0, fan});
  endtask : check_outs

  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    fails       = 0;
    check_count = 0;
    nrst_i      = 1'b0;
    ce_i        = 1'b1;
    ref_a       = 1'b0;
    ref_b       = 1'b0;
    void'($urandom(32'h1c67));
    repeat (2) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    ctl.load(11'h000, 0, 0);
    check_outs(10'h000, 1'b0);
    chk("locked", 11'h000, {10'h000, locked});
    for (int s = 0; s < 2; s++) begin
      ctl.std(1'(s));
      check_outs(10'h3FF, 1'(s));
      chk("mode", 11'h000, {10'h000, pmode});
    end
    for (int i = 0; i < 8; i++) begin
      w = (i < 4) ? corner[i] : 11'($urandom);
      ctl.pin_reset();
      ctl.load(w, 11, i % 3);
      chk("locked", 11'h000, {10'h000, locked});
      check_outs(10'h000, 1'b0);
      ctl.commit(i % 2);
      repeat (2) @(negedge sys_clk_i);
      chk("locked", 11'h001, {10'h000, locked});
      chk("mode", 11'h001, {10'h000, pmode});
      check_outs(exp_en(w), w[10]);
      ctl.load(~w, 11, 0);
      ctl.commit(0);
      check_outs(exp_en(w), w[10]);
    end
    // one pulse short: the eleventh rise is only the eleventh bit
    ctl.pin_reset();
    ctl.load(11'h7FF, 10, 0);
    ctl.commit(0);
    chk("locked", 11'h000, {10'h000, locked});
    check_outs(10'h000, 1'b0);
    ctl.pin_reset();
    ctl.load(11'h7FF, 11, 0);
    ctl.commit(0);
    ctl.std(1'b0);
    check_outs(10'h3FF, 1'b0);
    @(negedge sys_clk_i);
    ce_i = 1'b0;
    ctl.load(11'h000, 0, 0);
    repeat (3) @(negedge sys_clk_i);
    chk("frozen mode", 11'h000, {10'h000, pmode});
    ce_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk("mode", 11'h001, {10'h000, pmode});
    // control register survives a spell in standard mode
    check_outs(10'h3FF, 1'b1);
    // ****************************************
    // reset in mid-run
    // ****************************************
    @(negedge sys_clk_i);
    nrst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    chk("locked", 11'h000, {10'h000, locked});
    check_outs(10'h000, 1'b0);
    w = 11'($urandom);
    ctl.load(w, 11, 1);
    ctl.commit(0);
    repeat (2) @(negedge sys_clk_i);
    chk("locked", 11'h001, {10'h000, locked});
    check_outs(exp_en(w), w[10]);
    report_and_stop();
  end
endmodule : tb
